// *** logic/eeprom_consts.svh ***
// constants of the serial eeprom command and write-state block
`ifndef EEPROM_CONSTS_SVH
`define EEPROM_CONSTS_SVH

// op-codes
`define OPC_WRSR 8'h01
`define OPC_WRITE 8'h02
`define OPC_READ 8'h03
`define OPC_WRITE_DISABLE 8'h04
`define OPC_STATUS_READ 8'h05
`define OPC_WRITE_ENABLE 8'h06

// status byte layout and reset value
`define ST_BUSY_BIT 0
`define ST_LATCH_BIT 1
`define ST_WR_MASK 8'hdc
`define ST_RST 8'h00

// frame lengths in serial clocks
`define OPC_BITS 12'h008
`define WRSR_BITS 12'h010
`define HDR_BITS 12'h018
`define WR_MIN_BITS 12'h020
`define CNT_MAX 12'hfff

// self-timed write cycle
`define CLK_PERIOD_NS 5
`define WRITE_TIME_NS 5000
`define WRITE_CYC (`WRITE_TIME_NS / `CLK_PERIOD_NS)

`endif

// *** logic/eeprom_pkg.sv ***
// types of the serial eeprom command and write-state block
package eeprom_pkg;

  typedef enum logic [0:0] {
    PWR_RESET = 1'b0,
    PWR_STANDBY = 1'b1
  } pwr_t;

  typedef enum logic [2:0] {
    OP_NONE = 3'b000,
    OP_WRITE_ENABLE = 3'b001,
    OP_WRITE_DISABLE = 3'b010,
    OP_STATUS_READ = 3'b011,
    OP_WRSR = 3'b100,
    OP_READ = 3'b101,
    OP_WRITE = 3'b110
  } op_t;

  typedef logic [12:1] code_t;

endpackage

// *** logic/spi_eeprom_write_state_control.sv ***
// serial eeprom command acceptance, write-state control and ecc array
`timescale 1ns/1ps
`default_nettype none
`include "eeprom_consts.svh"

// What this block does
// R1: power-good high enters standby; power-good low returns to held reset.
// R2: leaving reset, device idles with write enable latch cleared.
// R3: host sends write-enable before every write; unarmed writes do nothing.
// R4: instructions accepted only after chip select is driven low.
// R5: completed array or status write clears the write enable latch.
// R6: internal write starts only on chip select rising after a valid whole-byte count.
// R7: array access during internal write is ignored; programming continues.
// R8: unknown op-code does nothing; data output stays undriven all frame.
// R9: each stored byte carries ecc correcting any single bit error.
// R10: write-enable frame closed by chip select sets latch and status bit.
// R11: write-disable clears the write enable latch.
// R12: during internal write only status read is serviced.
// R13: status busy bit high during internal write, low otherwise.
// R14: host polls busy until low before next command after a write.
// R15: write frame with wrong clock count is dropped, latch kept.
module spi_eeprom_write_state_control
  import eeprom_pkg::*;
#(
  parameter int ADDR_W = 5,
  parameter int unsigned WRITE_CYCLES = `WRITE_CYC
)
(
  input wire logic clock,
  input wire logic rst_b,
  input wire logic por_ok,
  input wire logic cs_b,
  input wire logic sck,
  input wire logic si,
  output logic so,
  output logic so_oe,
  output logic standby
);

  localparam int DEPTH = 1 << ADDR_W;

  // ----------------------------------------------------------------
  // ecc helpers
  // ----------------------------------------------------------------
  function automatic code_t ecc_enc(input logic [7:0] d);
    code_t c;
    int j;
    c = '0;
    j = 0;
    for (int i = 3; i <= 12; i++)
    begin
      if (i != 4 && i != 8)
      begin
        c[i] = d[j];
        j++;
      end
    end
    for (int k = 0; k < 4; k++)
      for (int i = 3; i <= 12; i++)
        if (((i >> k) & 1) == 1 && i != (1 << k))
          c[1 << k] = c[1 << k] ^ c[i];
    return c;
  endfunction

  function automatic logic [7:0] ecc_dec(input code_t cw);
    code_t c;
    logic [3:0] syn;
    logic [7:0] d;
    int j;
    c = cw;
    syn = 4'h0;
    d = 8'h00;
    j = 0;
    for (int i = 1; i <= 12; i++)
      if (c[i])
        syn = syn ^ 4'(i);
    // one flipped bit points at itself; zero syndrome means clean
    if (syn != 4'h0 && syn <= 4'hc)
      c[syn] = ~c[syn];
    for (int i = 3; i <= 12; i++)
    begin
      if (i != 4 && i != 8)
      begin
        d[j] = c[i];
        j++;
      end
    end
    return d;
  endfunction

  // ----------------------------------------------------------------
  // pin synchronisers
  // ----------------------------------------------------------------
  logic por_m, por_s, cs_m, cs_s, cs_d, sck_m, sck_s, sck_d, si_m, si_s;

  always_ff @(posedge clock or negedge rst_b)
  begin
    if (!rst_b)
    begin
      por_m <= 1'b0;
      por_s <= 1'b0;
      cs_m <= 1'b1;
      cs_s <= 1'b1;
      cs_d <= 1'b1;
      sck_m <= 1'b0;
      sck_s <= 1'b0;
      sck_d <= 1'b0;
      si_m <= 1'b0;
      si_s <= 1'b0;
    end
    else
    begin
      por_m <= por_ok;
      por_s <= por_m;
      cs_m <= cs_b;
      cs_s <= cs_m;
      cs_d <= cs_s;
      sck_m <= sck;
      sck_s <= sck_m;
      sck_d <= sck_s;
      si_m <= si;
      si_s <= si_m;
    end
  end

  // ----------------------------------------------------------------
  // power state and framing
  // ----------------------------------------------------------------
  pwr_t pwr_r;
  logic hold, frame_r, cs_fall, cs_rise, sck_rise, sck_fall;
  logic busy_r, write_enable_latch_r, wrsr_r, done;
  logic [11:0] cnt_r;
  logic [23:0] in_sr_r, sr_nxt;
  op_t op_r, op_now, op_dec;

  always_ff @(posedge clock or negedge rst_b)
  begin
    if (!rst_b)
      pwr_r <= PWR_RESET;
    else
      pwr_r <= por_s ? PWR_STANDBY : PWR_RESET; // R1
  end

  assign hold = (pwr_r == PWR_RESET);
  assign cs_fall = cs_d & ~cs_s;
  assign cs_rise = ~cs_d & cs_s;
  assign sck_rise = frame_r & ~sck_d & sck_s;
  assign sck_fall = frame_r & sck_d & ~sck_s;
  assign sr_nxt = {in_sr_r[22:0], si_s};
  assign standby = ~hold & ~frame_r & ~busy_r;

  // a select already low at power-up opens no frame
  always_ff @(posedge clock or negedge rst_b)
  begin
    if (!rst_b)
      frame_r <= 1'b0;
    else if (hold || cs_rise)
      frame_r <= 1'b0;
    else if (cs_fall)
      frame_r <= 1'b1; // R4
  end

  always_ff @(posedge clock or negedge rst_b)
  begin
    if (!rst_b)
    begin
      cnt_r <= 12'h000;
      in_sr_r <= 24'h000000;
    end
    else if (hold || cs_fall)
      cnt_r <= 12'h000;
    else if (sck_rise)
    begin
      in_sr_r <= sr_nxt;
      if (cnt_r != `CNT_MAX)
        cnt_r <= cnt_r + 12'h001;
    end
  end

  // ----------------------------------------------------------------
  // op-code decode
  // ----------------------------------------------------------------
  always_comb
  begin
    case (sr_nxt[7:0])
      `OPC_WRITE_ENABLE: op_dec = OP_WRITE_ENABLE;
      `OPC_WRITE_DISABLE: op_dec = OP_WRITE_DISABLE;
      `OPC_STATUS_READ: op_dec = OP_STATUS_READ;
      `OPC_WRSR: op_dec = OP_WRSR;
      `OPC_READ: op_dec = OP_READ;
      `OPC_WRITE: op_dec = OP_WRITE;
      default: op_dec = OP_NONE; // R8
    endcase
    if (busy_r && op_dec != OP_STATUS_READ)
      op_dec = OP_NONE; // R7 R12
  end

  assign op_now = (cnt_r == `OPC_BITS - 12'h001) ? op_dec : op_r;

  always_ff @(posedge clock or negedge rst_b)
  begin
    if (!rst_b)
      op_r <= OP_NONE;
    else if (hold || cs_fall)
      op_r <= OP_NONE;
    else if (sck_rise && cnt_r == `OPC_BITS - 12'h001)
      op_r <= op_dec;
  end

  // ----------------------------------------------------------------
  // address, page buffer and frame end
  // ----------------------------------------------------------------
  logic [ADDR_W-1:0] addr_r, rd_idx;
  logic [7:0] pbuf_r [DEPTH];
  logic [DEPTH-1:0] pmask_r;
  logic byte_edge, wr_go;
  logic [7:0] st_bits_r, st_pend_r, status;
  logic [15:0] wait_r;

  assign byte_edge = sck_rise && cnt_r[2:0] == 3'h7;
  assign rd_idx = (cnt_r == `HDR_BITS - 12'h001) ?
                  sr_nxt[ADDR_W-1:0] : addr_r;

  always_ff @(posedge clock or negedge rst_b)
  begin
    if (!rst_b)
    begin
      addr_r <= '0;
      pmask_r <= '0;
    end
    // status polls during a write must not wipe the pending page
    else if (hold || (cs_fall && !busy_r))
      pmask_r <= '0;
    else if (byte_edge && cnt_r >= `HDR_BITS - 12'h001)
    begin
      if (op_r == OP_READ)
        addr_r <= rd_idx + 1'b1;
      else if (op_r == OP_WRITE && cnt_r == `HDR_BITS - 12'h001)
        addr_r <= sr_nxt[ADDR_W-1:0];
      else if (op_r == OP_WRITE)
      begin
        // page wraps, later bytes overwrite earlier ones
        pbuf_r[addr_r] <= sr_nxt[7:0];
        pmask_r[addr_r] <= 1'b1;
        addr_r <= addr_r + 1'b1;
      end
    end
  end

  // whole-byte count only (at least 32 for a write, exactly 16 for status write), and only when armed
  assign wr_go = cs_rise && !hold && write_enable_latch_r &&
    ((op_r == OP_WRITE && cnt_r >= `WR_MIN_BITS && cnt_r[2:0] == 3'h0) ||
     (op_r == OP_WRSR && cnt_r == `WRSR_BITS)); // R3 R6 R15
  assign done = busy_r && wait_r == 16'h0000;

  // ----------------------------------------------------------------
  // self-timed write cycle
  // ----------------------------------------------------------------
  always_ff @(posedge clock or negedge rst_b)
  begin
    if (!rst_b)
    begin
      busy_r <= 1'b0;
      wait_r <= 16'h0000;
      wrsr_r <= 1'b0;
      st_pend_r <= `ST_RST;
    end
    else if (hold)
      busy_r <= 1'b0;
    else if (wr_go)
    begin
      busy_r <= 1'b1; // R6 R13
      wait_r <= 16'(WRITE_CYCLES - 1);
      wrsr_r <= (op_r == OP_WRSR);
      st_pend_r <= in_sr_r[7:0];
    end
    else if (done)
      busy_r <= 1'b0; // R13
    else if (busy_r)
      wait_r <= wait_r - 16'h0001; // R7
  end

  always_ff @(posedge clock or negedge rst_b)
  begin
    if (!rst_b)
      write_enable_latch_r <= 1'b0; // R2
    else if (hold || done)
      write_enable_latch_r <= 1'b0; // R2 R5
    else if (cs_rise && cnt_r == `OPC_BITS && op_r == OP_WRITE_ENABLE)
      write_enable_latch_r <= 1'b1; // R10
    else if (cs_rise && cnt_r == `OPC_BITS && op_r == OP_WRITE_DISABLE)
      write_enable_latch_r <= 1'b0; // R11
  end

  // ----------------------------------------------------------------
  // array and status commit
  // ----------------------------------------------------------------
  code_t mem_r [DEPTH];

  always_ff @(posedge clock or negedge rst_b)
  begin
    if (!rst_b)
      st_bits_r <= `ST_RST;
    else if (done && wrsr_r)
      st_bits_r <= st_pend_r & `ST_WR_MASK;
  end

  // array content survives brown-out, so it has no reset
  always_ff @(posedge clock)
  begin
    if (done && !wrsr_r && !hold)
      for (int i = 0; i < DEPTH; i++)
        if (pmask_r[i])
          mem_r[i] <= ecc_enc(pbuf_r[i]); // R9
  end

  always_comb
  begin
    status = st_bits_r;
    status[`ST_BUSY_BIT] = busy_r; // R13
    status[`ST_LATCH_BIT] = write_enable_latch_r; // R10
  end

  // ----------------------------------------------------------------
  // serial output
  // ----------------------------------------------------------------
  logic [7:0] out_sr_r;
  logic so_r, so_oe_r, load_st, load_rd;

  assign load_st = byte_edge && op_now == OP_STATUS_READ;
  assign load_rd = byte_edge && op_r == OP_READ &&
                   cnt_r >= `HDR_BITS - 12'h001;

  always_ff @(posedge clock or negedge rst_b)
  begin
    if (!rst_b)
    begin
      out_sr_r <= 8'h00;
      so_r <= 1'b0;
      so_oe_r <= 1'b0;
    end
    else if (hold || cs_rise || cs_fall)
      so_oe_r <= 1'b0; // R8
    else if (load_st || load_rd)
    begin
      out_sr_r <= load_st ? status : ecc_dec(mem_r[rd_idx]); // R9 R12
      so_oe_r <= 1'b1;
    end
    else if (sck_fall && so_oe_r)
    begin
      so_r <= out_sr_r[7];
      out_sr_r <= {out_sr_r[6:0], 1'b0};
    end
  end

  assign so = so_r;
  assign so_oe = so_oe_r;

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  default clocking cb @(posedge clock); endclocking
  default disable iff (!rst_b);

  logic [11:0] flip_r;
  always_ff @(posedge clock or negedge rst_b)
  begin
    if (!rst_b)
      flip_r <= 12'h001;
    else
      flip_r <= {flip_r[10:0], flip_r[11]};
  end

  // busy length counter; too long a span for a sequence delay
  logic [15:0] run_r;
  always_ff @(posedge clock or negedge rst_b)
  begin
    if (!rst_b)
      run_r <= 16'h0000;
    else if (!busy_r)
      run_r <= 16'h0000;
    else
      run_r <= run_r + 16'h0001;
  end

  a_power_follow: assert property (por_s != $past(por_s) |=> // R1
    (pwr_r == PWR_STANDBY) == $past(por_s))
    else $error("power state does not follow power good");
  a_reset_disarm: assert property (hold |=> // R2
    !write_enable_latch_r && !busy_r)
    else $error("latch or busy set in reset");
  a_cs_gate: assert property (!frame_r && !cs_fall && !hold |=> // R4
    $stable(cnt_r))
    else $error("clock counted outside a frame");
  a_latch_autoclr: assert property ($fell(busy_r) |-> // R5
    !write_enable_latch_r)
    else $error("latch still set after write cycle");
  a_start_edge: assert property ($rose(busy_r) |-> // R6
    $past(cs_rise) && $past(write_enable_latch_r))
    else $error("write cycle began without armed frame end");
  a_busy_full: assert property ($fell(busy_r) && !$past(hold) |-> // R7
    $past(run_r) == 16'(WRITE_CYCLES - 1))
    else $error("write cycle length wrong");
  a_busy_len: assert property ($rose(busy_r) |-> // R7
    busy_r [*8] ##0 wait_r == 16'(WRITE_CYCLES - 8))
    else $error("write cycle cut short");
  a_invalid_quiet: assert property (frame_r && op_r == OP_NONE && // R8
    cnt_r >= `OPC_BITS |-> !so_oe_r)
    else $error("output driven for ignored op-code");
  a_ecc_single: assert property ( // R9
    ecc_dec(ecc_enc(in_sr_r[7:0]) ^ flip_r) == in_sr_r[7:0])
    else $error("single bit error not corrected");
  a_latch_set: assert property (cs_rise && !hold && // R10
    op_r == OP_WRITE_ENABLE && cnt_r == `OPC_BITS && !busy_r |=>
    write_enable_latch_r)
    else $error("write enable not latched");
  a_latch_clr: assert property (cs_rise && !hold && // R11
    op_r == OP_WRITE_DISABLE && cnt_r == `OPC_BITS |=>
    !write_enable_latch_r)
    else $error("write disable did not clear latch");
  a_busy_filter: assert property (busy_r && frame_r && // R12
    op_r != OP_NONE |-> op_r == OP_STATUS_READ)
    else $error("command accepted during write cycle");
  a_status_busy: assert property (load_st |=> // R13
    out_sr_r[`ST_BUSY_BIT] == $past(busy_r))
    else $error("status busy bit wrong");
  a_bad_count: assert property (cs_rise && op_r == OP_WRITE && // R15
    cnt_r[2:0] != 3'h0 && !hold |=> !busy_r &&
    write_enable_latch_r == $past(write_enable_latch_r))
    else $error("misframed write started or disarmed");

  c_write_run: cover property (busy_r &&
    run_r == 16'(WRITE_CYCLES - 1) ##1 !busy_r);
  c_poll_busy: cover property (load_st && busy_r);
  c_bad_op: cover property (sck_rise && cnt_r == 12'h007 &&
    op_dec == OP_NONE && !busy_r);
  c_read_byte: cover property (load_rd);

endmodule
`default_nettype wire

// *** tb/spi_host_model.sv ***
// spi host model driving select, clock and data of the eeprom
`timescale 1ns/1ps
`default_nettype none
module spi_host_model
(
  input wire logic clock,
  input wire logic so,
  input wire logic so_oe,
  output logic cs_b,
  output logic sck,
  output logic si,
  output logic saw_oe
);
  // 16 clocks per phase leaves the synchronisers plenty of margin
  localparam int HALF = 16;
  logic last_r;
  initial
  begin
    cs_b = 1'b1;
    sck = 1'b0;
    si = 1'b0;
    saw_oe = 1'b0;
    last_r = 1'b0;
  end
  always @(posedge clock)
  begin
    if (so_oe)
      saw_oe <= 1'b1;
  end
  task automatic wait_n(input int n);
    repeat (n) @(negedge clock);
  endtask
  // mode 0 frame, msb first; sck rests low between frames
  task automatic xfer(input int nbits, input logic [63:0] tx,
                      output logic [63:0] rx);
    rx = '0;
    saw_oe = 1'b0;
    cs_b = 1'b0;
    wait_n(HALF);
    for (int i = nbits - 1; i >= 0; i--)
    begin
      si = tx[i];
      wait_n(HALF);
      sck = 1'b1;
      // undriven so never mimics the last value seen
      rx = {rx[62:0], so_oe ? so : ~last_r};
      last_r = rx[0];
      wait_n(HALF);
      sck = 1'b0;
    end
    si = ~si;
    wait_n(HALF);
    cs_b = 1'b1;
    wait_n(4 * HALF);
  endtask
endmodule
`default_nettype wire

// *** tb/testbench.sv ***
// self-checking bench of the eeprom write-state block
`timescale 1ns/1ps
`default_nettype none
`include "eeprom_consts.svh"
module testbench;
  logic clock;
  logic rst_b;
  logic por_ok;
  wire logic cs_b;
  wire logic sck;
  wire logic si;
  wire logic so;
  wire logic so_oe;
  wire logic standby;
  wire logic saw_oe;
  int n_errors;
  int n_checks;
  logic [63:0] rx;
  logic [7:0] st;

  spi_eeprom_write_state_control #(.WRITE_CYCLES(3000))
    u_spi_eeprom_write_state_control
  (
    .clock(clock), .rst_b(rst_b), .por_ok(por_ok), .cs_b(cs_b),
    .sck(sck), .si(si), .so(so), .so_oe(so_oe), .standby(standby)
  );
  spi_host_model u_spi_host_model
  (
    .clock(clock), .so(so), .so_oe(so_oe), .cs_b(cs_b), .sck(sck),
    .si(si), .saw_oe(saw_oe)
  );

  initial clock = 1'b0;
  always #2.5 clock = ~clock;

  // ----------------------------------------
  // compare and closing
  // ----------------------------------------
  task automatic chk8(input string what, input logic [7:0] e,
                      input logic [7:0] g);
    n_checks++;
    if (g !== e)
    begin
      n_errors++;
      $display("MISMATCH %s expected %h seen %h", what, e, g);
    end
  endtask
  task automatic chk1(input string what, input logic e, input logic g);
    chk8(what, {7'h00, e}, {7'h00, g});
  endtask
  task automatic close_out();
    $display("checks %0d errors %0d", n_checks, n_errors);
    if (n_errors == 0 && n_checks > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask
  task automatic status_read();
    u_spi_host_model.xfer(16, {`OPC_STATUS_READ, 8'h00}, rx);
    st = rx[7:0];
  endtask
  task automatic cmd(input logic [7:0] op);
    u_spi_host_model.xfer(8, op, rx);
  endtask

  // ----------------------------------------
  // scenarios
  // ----------------------------------------
  task automatic t_power_up();
    chk1("standby in reset", 1'b0, standby);
    por_ok = 1'b1;
    repeat (10) @(negedge clock);
    chk1("standby", 1'b1, standby);
    status_read();
    chk8("status after power", 8'h00, st);
    $display("test power_up done");
  endtask
  task automatic t_latch();
    cmd(`OPC_WRITE_ENABLE);
    status_read();
    chk8("status after arm", 8'h02, st);
    cmd(`OPC_WRITE_DISABLE);
    status_read();
    chk8("status after disarm", 8'h00, st);
    u_spi_host_model.xfer(32, {`OPC_WRITE, 16'h0001, 8'h5a}, rx);
    status_read();
    chk8("status unarmed write", 8'h00, st);
    $display("test latch done");
  endtask
  task automatic t_bad_count();
    cmd(`OPC_WRITE_ENABLE);
    u_spi_host_model.xfer(33, {`OPC_WRITE, 16'h0000, 8'h11, 1'b0}, rx);
    status_read();
    chk8("status odd count", 8'h02, st);
    $display("test bad_count done");
  endtask
  task automatic t_write();
    u_spi_host_model.xfer(32, {`OPC_WRITE, 16'h0003, 8'ha5}, rx);
    status_read();
    chk8("status busy", 8'h03, st);
    u_spi_host_model.xfer(32, {`OPC_READ, 16'h0003, 8'h00}, rx);
    chk1("output during write", 1'b0, saw_oe);
    // poll bounded so a stuck busy bit fails rather than hangs
    for (int i = 0; i < 20 && st[0] !== 1'b0; i++)
      status_read();
    chk8("status after write", 8'h00, st);
    u_spi_host_model.xfer(32, {`OPC_READ, 16'h0003, 8'h00}, rx);
    chk8("read back", 8'ha5, rx[7:0]);
    chk1("output on read", 1'b1, saw_oe);
    $display("test write done");
  endtask
  task automatic t_bad_op();
    u_spi_host_model.xfer(16, {8'hff, 8'h00}, rx);
    chk1("output on bad code", 1'b0, saw_oe);
    $display("test bad_op done");
  endtask
  task automatic t_brownout();
    cmd(`OPC_WRITE_ENABLE);
    por_ok = 1'b0;
    repeat (10) @(negedge clock);
    chk1("standby low power", 1'b0, standby);
    por_ok = 1'b1;
    repeat (10) @(negedge clock);
    status_read();
    chk8("status after brownout", 8'h00, st);
    $display("test brownout done");
  endtask

  initial
  begin
    rst_b = 1'b0;
    por_ok = 1'b0;
    n_errors = 0;
    n_checks = 0;
    repeat (4) @(negedge clock);
    rst_b = 1'b1;
    t_power_up();
    t_latch();
    t_bad_count();
    t_write();
    t_bad_op();
    t_brownout();
    close_out();
  end

  // tests need about 14000 clocks; allow ample slack
  initial
  begin
    repeat (80000) @(posedge clock);
    n_errors++;
    close_out();
  end
endmodule
`default_nettype wire
